// >>> rtl/host_port_pkg.sv
/*
 * constants, config/request carriers and the frame check function of the
 * host serial port. assumes a 40 MHz system clock and a register map
 * that lives outside this block.
 */
package host_port_pkg;

   // clock and uart timing
   localparam int CLK_HZ = 40_000_000;
   localparam int UART_BAUD = 9600;
   localparam int BAUD_DIV = CLK_HZ / UART_BAUD;

   // frame layout
   localparam logic [5:0] FRAME_LONG = 6'h20;
   localparam logic [5:0] FRAME_SHORT = 6'h18;
   localparam logic [5:0] CNT_MAX = 6'h3F;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_NONE = 8'h00;
   localparam logic [15:0] DATA_ZERO = 16'h0000;
   localparam logic [31:0] SR_RST = 32'h0000_0000;

   // break-mode control register
   localparam logic [6:0] BRK_CTRL_ADDR = 7'h7F;
   localparam int MAP_BIT = 0;
   localparam logic MAP_RST = 1'b0;
   localparam logic [1:0] UBM_LAST = 2'h2;

   // pin synchroniser order and idle levels: {uart_rx, sdi, cs_n, sclk}
   localparam logic [3:0] PIN_INIT = 4'hA;

   typedef struct packed {
      logic serial_uart_off;
      logic readout_drive_off;
      logic readback_output_gate;
      logic readout_edge_select;
      logic interrupt_pin_on;
      logic clear_function_pin_on;
      logic frame_check_on;
   } cfg_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   localparam reg_req_t REQ_IDLE = '{wr: 1'b0, rd: 1'b0, addr: 7'h00, wdata: 16'h0000};

   // msb-first crc over 24 bits, zero start value
   function automatic logic [7:0] crc8_24(input logic [23:0] d);
      logic [7:0] c;
      logic fb;
      c = CRC_NONE;
      for (int i = 23; i >= 0; i--) begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : CRC_NONE);
      end
      return c;
   endfunction

endpackage

// >>> rtl/pin_sync.sv
/*
 * three-stage synchroniser for a group of pins with stable level and
 * one-cycle edge pulses. assumes pins are asynchronous to clk_sys_i.
 */
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] lvl_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] lvl_ff;
   logic [W-1:0] rise_ff;
   logic [W-1:0] fall_ff;
   logic [W-1:0] nxt_lvl;

   // a bit only moves when stage two and three agree, which filters runts
   assign nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));

   // shift chain; s1 feeds s2 only
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         s1_ff <= INIT;
         s2_ff <= INIT;
         s3_ff <= INIT;
      end else begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // stable level and edges
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         lvl_ff <= INIT;
         rise_ff <= '0;
         fall_ff <= '0;
      end else begin
         lvl_ff <= nxt_lvl;
         rise_ff <= nxt_lvl & ~lvl_ff;
         fall_ff <= ~nxt_lvl & lvl_ff;
      end
   end

   assign lvl_o = lvl_ff;
   assign rise_o = rise_ff;
   assign fall_o = fall_ff;
endmodule

// >>> rtl/uart_rx.sv
/*
 * 8O1 uart character receiver with break detection. assumes rxd_i is
 * already synchronised and idles high.
 */
`timescale 1ns/1ps
module uart_rx #(
   parameter int DIV = 4166
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic en_i,
   input wire logic rxd_i,
   output logic byte_vld_o,
   output logic [7:0] byte_o,
   output logic brk_o
);
   typedef enum logic [1:0] {HUNT, IDLE, RUN} rx_state_t;

   rx_state_t state_ff;
   logic [15:0] cnt_ff;
   logic [3:0] bit_ff;
   logic [10:0] sh_ff;
   logic vld_ff;
   logic brk_ff;
   logic [7:0] byte_ff;
   logic [10:0] ch;

   // character as it stands after the stop sample
   assign ch = {rxd_i, sh_ff[9:0]};

   // bit timing: start is found mid-bit, then one sample per bit period
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         state_ff <= HUNT;
         cnt_ff <= 16'h0000;
         bit_ff <= 4'h0;
         sh_ff <= 11'h000;
      end else if (!en_i) begin
         state_ff <= HUNT;
      end else begin
         unique case (state_ff)
            // a break holds the line low, so wait for idle before arming
            HUNT: if (rxd_i) state_ff <= IDLE;
            IDLE: begin
               if (!rxd_i) begin
                  state_ff <= RUN;
                  cnt_ff <= 16'(DIV / 2);
                  bit_ff <= 4'h0;
               end
            end
            RUN: begin
               if (cnt_ff == 16'h0000) begin
                  sh_ff[bit_ff] <= rxd_i;
                  cnt_ff <= 16'(DIV - 1);
                  bit_ff <= bit_ff + 4'h1;
                  if (bit_ff == 4'hA) state_ff <= HUNT;
               end else begin
                  cnt_ff <= cnt_ff - 16'h0001;
               end
            end
         endcase
      end
   end

   // judge the character at the stop sample
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         vld_ff <= 1'b0;
         brk_ff <= 1'b0;
         byte_ff <= 8'h00;
      end else begin
         vld_ff <= 1'b0;
         brk_ff <= 1'b0;
         if (en_i && state_ff == RUN && cnt_ff == 16'h0000 && bit_ff == 4'hA) begin
            if (ch == 11'h000) begin
               brk_ff <= 1'b1;
            end else if (ch[10] && !ch[0] && (^ch[9:1])) begin
               vld_ff <= 1'b1;
               byte_ff <= ch[8:1];
            end
         end
      end
   end

   assign byte_vld_o = vld_ff;
   assign byte_o = byte_ff;
   assign brk_o = brk_ff;
endmodule

// >>> rtl/host_serial_port.sv
/*
 * host serial port: spi slave with frame crc plus break-framed uart
 * access, with mode selection and pin sharing. assumes the register map
 * sits outside and answers reg_rdata_i in the cycle a read strobe is high.
 */
`timescale 1ns/1ps
module host_serial_port #(
   parameter int BAUD_CYCLES = host_port_pkg::BAUD_DIV,
   parameter logic [6:0] BRK_ADDR = host_port_pkg::BRK_CTRL_ADDR
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   input wire logic uart_rx_i,
   output logic uart_tx_o,
   input wire host_port_pkg::cfg_t cfg_i,
   input wire logic [5:0] status_i,
   input wire logic irq_req_i,
   input wire logic [15:0] reg_rdata_i,
   output host_port_pkg::reg_req_t reg_req_o,
   output logic uart_map_access_o,
   output logic clear_trig_o
);
   import host_port_pkg::*;

   logic [3:0] pin_lvl;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;
   logic cs_low;
   logic sclk_fall;
   logic sclk_rise;
   logic sdi_lvl;
   logic [31:0] in_sr_ff;
   logic [5:0] cnt_ff;
   logic [31:0] tx_sr_ff;
   logic [31:0] nxt_tx;
   logic fl_long;
   logic full;
   logic [23:0] word;
   logic crc_ok;
   logic commit;
   logic spi_ok;
   logic crc_fail_ff;
   logic resp_rw_ff;
   logic [15:0] resp_data_ff;
   logic [23:0] resp24;
   logic shift_ev;
   logic fill;
   reg_req_t reg_req_ff;
   logic sdo_ff;
   logic sdo_oe_ff;
   logic uart_tx_ff;
   logic clear_ff;
   logic uart_map_ff;
   logic uart_en;
   logic rx_vld;
   logic [7:0] rx_byte;
   logic rx_brk;
   logic ubm_arm_ff;
   logic [1:0] ubm_cnt_ff;
   logic [23:0] ubm_sr_ff;
   logic ubm_done_ff;

   // all pins pass the same three stages, so edges keep their order
   pin_sync #(.W(4), .INIT(PIN_INIT)) u_pins (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .pin_i({uart_rx_i, sdi_i, cs_n_i, sclk_i}),
      .lvl_o(pin_lvl),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   // only sclk edges matter, never its idle level, so both polarities work
   assign cs_low = !pin_lvl[1];
   assign sclk_fall = pin_fall[0] && cs_low;
   assign sclk_rise = pin_rise[0] && cs_low;
   assign sdi_lvl = pin_lvl[2];
   assign uart_en = !cfg_i.serial_uart_off;

   // uart receiver runs from reset, so either protocol may come first
   uart_rx #(.DIV(BAUD_CYCLES)) u_rx (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .en_i(uart_en),
      .rxd_i(pin_lvl[3]),
      .byte_vld_o(rx_vld),
      .byte_o(rx_byte),
      .brk_o(rx_brk)
   );

   // input shift register keeps the newest 32 bits, count saturates
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         in_sr_ff <= SR_RST;
         cnt_ff <= 6'h00;
      end else if (pin_fall[1]) begin
         cnt_ff <= 6'h00;
      end else if (sclk_fall) begin
         in_sr_ff <= {in_sr_ff[30:0], sdi_lvl};
         if (cnt_ff != CNT_MAX) cnt_ff <= cnt_ff + 6'h01;
      end
   end

   // frame decode, right-justified in the shift register
   assign fl_long = cfg_i.frame_check_on;
   assign full = cnt_ff >= (fl_long ? FRAME_LONG : FRAME_SHORT);
   assign word = fl_long ? in_sr_ff[31:8] : in_sr_ff[23:0];
   assign crc_ok = !fl_long || (crc8_24(in_sr_ff[31:8]) == in_sr_ff[7:0]);
   assign commit = pin_rise[1] && full;
   assign spi_ok = !uart_map_ff && (word[22:16] != BRK_ADDR);

   // crc fail status reflects only the last full frame
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         crc_fail_ff <= 1'b0;
         resp_rw_ff <= 1'b0;
      end else if (commit) begin
         crc_fail_ff <= !crc_ok;
         resp_rw_ff <= word[23];
      end
   end

   // response data: zero after a write or a blocked read, register contents after a read that reaches the map
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         resp_data_ff <= DATA_ZERO;
      end else if (commit && crc_ok) begin
         if (!word[23] || !spi_ok) resp_data_ff <= DATA_ZERO;
      end else if (reg_req_ff.rd && !uart_map_ff) begin
         resp_data_ff <= reg_rdata_i;
      end
   end

   // register strobes, one cycle each, from spi or from a uart packet
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         reg_req_ff <= REQ_IDLE;
      end else begin
         reg_req_ff.wr <= 1'b0;
         reg_req_ff.rd <= 1'b0;
         if (commit && crc_ok && spi_ok) begin
            reg_req_ff.wr <= !word[23];
            reg_req_ff.rd <= word[23];
            reg_req_ff.addr <= word[22:16];
            reg_req_ff.wdata <= word[15:0];
         end else if (ubm_done_ff && uart_map_ff && ubm_sr_ff[22:16] != BRK_ADDR) begin
            reg_req_ff.wr <= !ubm_sr_ff[23];
            reg_req_ff.rd <= ubm_sr_ff[23];
            reg_req_ff.addr <= ubm_sr_ff[22:16];
            reg_req_ff.wdata <= ubm_sr_ff[15:0];
         end
      end
   end

   // output frame: rw flag, crc fail flag, status, data, then crc of those 24 bits in long frames, zeros in short frames
   assign resp24 = {resp_rw_ff, crc_fail_ff, status_i, resp_data_ff};
   // the first rising edge of an idle-low clock precedes any sample; skip it
   assign shift_ev = cfg_i.readout_edge_select ? sclk_fall : (sclk_rise && cnt_ff != 6'h00);
   assign fill = cfg_i.readout_edge_select ? sdi_lvl : in_sr_ff[0];

   // surplus bits enter just behind the frame, so they leave a frame later
   always_comb begin
      nxt_tx = {tx_sr_ff[30:0], fill};
      if (!fl_long) begin
         nxt_tx[8] = fill;
         nxt_tx[7:0] = CRC_NONE;
      end
   end

   // load at cs fall so the msb is on the line before any clock
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         tx_sr_ff <= SR_RST;
      end else if (pin_fall[1]) begin
         tx_sr_ff <= {resp24, fl_long ? crc8_24(resp24) : CRC_NONE};
      end else if (shift_ev) begin
         tx_sr_ff <= nxt_tx;
      end
   end

   // sdo pin: readback in spi mode, interrupt request in uart mode
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         sdo_ff <= 1'b0;
         sdo_oe_ff <= 1'b0;
      end else if (uart_map_ff) begin
         sdo_oe_ff <= cfg_i.interrupt_pin_on;
         sdo_ff <= cfg_i.interrupt_pin_on && irq_req_i;
      end else begin
         // undriven when gated off: saves power and keeps the bus free
         sdo_oe_ff <= cs_low && !cfg_i.readback_output_gate
                      && !cfg_i.readout_drive_off;
         sdo_ff <= cs_low && tx_sr_ff[31];
      end
   end

   // uart tx pin idles high, or follows the interrupt request in spi mode when interrupt_pin_on is set; no uart transmit path here
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         uart_tx_ff <= 1'b1;
         clear_ff <= 1'b0;
      end else begin
         uart_tx_ff <= (!uart_map_ff && cfg_i.interrupt_pin_on) ? irq_req_i : 1'b1;
         clear_ff <= uart_map_ff && cfg_i.clear_function_pin_on && sdi_lvl;
      end
   end

   // break starts a packet of three characters, same layout as a short frame
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ubm_arm_ff <= 1'b0;
         ubm_cnt_ff <= 2'h0;
         ubm_sr_ff <= 24'h00_0000;
         ubm_done_ff <= 1'b0;
      end else begin
         ubm_done_ff <= 1'b0;
         if (!uart_en) begin
            ubm_arm_ff <= 1'b0;
         end else if (rx_brk) begin
            ubm_arm_ff <= 1'b1;
            ubm_cnt_ff <= 2'h0;
         end else if (rx_vld && ubm_arm_ff) begin
            ubm_sr_ff <= {ubm_sr_ff[15:0], rx_byte};
            ubm_cnt_ff <= ubm_cnt_ff + 2'h1;
            if (ubm_cnt_ff == UBM_LAST) begin
               ubm_arm_ff <= 1'b0;
               ubm_done_ff <= 1'b1;
            end
         end
      end
   end

   // break-mode control register: only a uart write reaches it
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         uart_map_ff <= MAP_RST;
      end else if (ubm_done_ff && !ubm_sr_ff[23] && ubm_sr_ff[22:16] == BRK_ADDR) begin
         uart_map_ff <= ubm_sr_ff[MAP_BIT];
      end
   end

   assign sdo_o = sdo_ff;
   assign sdo_oe_o = sdo_oe_ff;
   assign uart_tx_o = uart_tx_ff;
   assign reg_req_o = reg_req_ff;
   assign uart_map_access_o = uart_map_ff;
   assign clear_trig_o = clear_ff;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   a_gate_hiz: assert property (
      (cfg_i.readback_output_gate && !uart_map_ff) |=> !sdo_oe_o)
      else $error("sdo driven while readback gated");
   a_cs_high_hiz: assert property (
      (!cs_low && !uart_map_ff) |=> !sdo_oe_o)
      else $error("sdo driven with cs high");
   a_short_drop: assert property (
      (pin_rise[1] && !full && !ubm_done_ff) |=> (!reg_req_o.wr && !reg_req_o.rd))
      else $error("short frame executed");
   a_crc_block: assert property (
      (commit && !crc_ok && !ubm_done_ff) |=> (!reg_req_o.wr && crc_fail_ff))
      else $error("bad crc frame executed or not flagged");
   a_spi_write_go: assert property (
      (commit && crc_ok && spi_ok && !word[23]) |=>
      (reg_req_o.wr && reg_req_o.addr == $past(word[22:16])
       && reg_req_o.wdata == $past(word[15:0])))
      else $error("spi write not issued");
   a_brk_spi_block: assert property (
      (commit && word[22:16] == BRK_ADDR && !ubm_done_ff) |=>
      (!reg_req_o.wr && $stable(uart_map_ff)))
      else $error("spi reached break-mode register");
   a_map_blocks_spi: assert property (
      (commit && uart_map_ff && !ubm_done_ff) |=> !reg_req_o.wr)
      else $error("spi write while uart owns the map");
   a_irq_on_tx: assert property (
      (!uart_map_ff && cfg_i.interrupt_pin_on) |=> (uart_tx_o == $past(irq_req_i)))
      else $error("uart tx pin not following interrupt");
   a_irq_on_sdo: assert property (
      (uart_map_ff && cfg_i.interrupt_pin_on) |=> (sdo_oe_o && sdo_o == $past(irq_req_i)))
      else $error("sdo not carrying interrupt in uart mode");
   a_reset_map: assert property (
      @(posedge clk_sys_i) disable iff (1'b0) !rstn_i |=> !uart_map_access_o)
      else $error("break-mode register survived reset");
   a_read_data: assert property (
      (reg_req_ff.rd && !uart_map_ff) |=> (resp_data_ff == $past(reg_rdata_i))[*2])
      else $error("read data not held for response");
   a_short_keep: assert property (
      (pin_rise[1] && !full && !reg_req_ff.rd) |=>
      ($stable(resp_data_ff) && $stable(crc_fail_ff)))
      else $error("discarded frame changed the response");
   a_uart_off_idle: assert property (
      !uart_en |=> !ubm_arm_ff)
      else $error("uart packet armed while uart is off");
   a_load_msb: assert property (
      pin_fall[1] |=> (tx_sr_ff[31:8] == $past(resp24)))
      else $error("response not loaded at cs fall");
   a_clear_follow: assert property (
      (uart_map_ff && cfg_i.clear_function_pin_on) |=> (clear_trig_o == $past(sdi_lvl)))
      else $error("clear trigger not following sdi");
endmodule

// >>> rtl/unused_placeholder_removed.sv
/*
 * empty compilation unit kept intentionally minimal; holds no logic.
 * assumes nothing of its surroundings.
 */

// >>> tb/host_model.sv
/*
 * host-side partner: spi master, break-framed uart sender and a map stub.
 * assumes clk_sys_i is the bench clock; pins change on its falling edge.
 */
`timescale 1ns/1ps
module host_model #(
   parameter int BAUD = 16
) (
   input wire logic clk_sys_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   input wire logic [6:0] addr_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdi_o,
   output logic uart_rx_o,
   output logic [15:0] rdata_o
);
   // map stub: read data carries the address so each read is unique
   assign rdata_o = {addr_i, ~addr_i, addr_i[1:0]};

   // idle pins at time zero
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
      uart_rx_o = 1'b1;
   end

   task automatic hp(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   // one frame msb first; half period is 4 clocks, sdo is read late in each
   // bit so the device's synchroniser lag is covered
   task automatic spi(input logic [39:0] d, input int n, input logic cp,
                      input logic fe, output logic [39:0] q, output logic oe);
      q = '0;
      oe = 1'b0;
      // idle level moves while cs is high, where the device ignores sclk
      sclk_o = cp;
      hp(1);
      cs_n_o = 1'b0;
      sdi_o = d[n-1];
      hp(8);
      for (int i = n - 1; i >= 0; i--) begin
         repeat (2) begin
            if (fe && sclk_o)
               q[i] = sdo_i;
            sclk_o = ~sclk_o;
            hp(4);
            // next bit only after the sampling fall, never on it
            if (!sclk_o && i > 0)
               sdi_o = d[i-1];
         end
         if (!fe)
            q[i] = sdo_i;
         oe |= sdo_oe_i;
      end
      hp(4);
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      hp(12);
   endtask

   task automatic ubit(input logic b);
      uart_rx_o = b;
      hp(BAUD);
   endtask

   // break, then three 8O1 characters lsb first
   task automatic ucmd(input logic [23:0] w);
      logic [7:0] c;
      repeat (11) ubit(1'b0);
      repeat (3) ubit(1'b1);
      for (int k = 2; k >= 0; k--) begin
         c = w[8*k+:8];
         ubit(1'b0);
         for (int j = 0; j < 8; j++)
            ubit(c[j]);
         ubit(~^c);
         repeat (2) ubit(1'b1);
      end
   endtask
endmodule

// >>> tb/tb.sv
/*
 * self-checking bench of the host serial port, frames driven by host_model.
 * assumes the design package is compiled first; uart runs at 16 clocks a bit.
 */
`timescale 1ns/1ps
module tb;
   import host_port_pkg::*;
   logic clk_sys_i, rstn_i, sclk, cs_n, sdi, sdo, sdo_oe, urx, utx, irq, map, clr, oe;
   cfg_t cfg;
   logic [5:0] st;
   logic [15:0] rdata;
   logic [39:0] q;
   reg_req_t req, last;
   int n_mismatch, checked, n_wr, n_rd, cyc;
   wire sdo_pin = sdo_oe ? sdo : 1'bz;

   host_serial_port #(.BAUD_CYCLES(16)) i_dut (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .uart_rx_i(urx), .uart_tx_o(utx),
      .cfg_i(cfg), .status_i(st), .irq_req_i(irq), .reg_rdata_i(rdata),
      .reg_req_o(req), .uart_map_access_o(map), .clear_trig_o(clr));

   host_model #(.BAUD(16)) i_host (
      .clk_sys_i(clk_sys_i), .sdo_i(sdo_pin), .sdo_oe_i(sdo_oe), .addr_i(req.addr),
      .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .uart_rx_o(urx), .rdata_o(rdata));

   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic report_and_stop();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // strobes are one cycle wide, so count them here; also the hang limit
   always @(posedge clk_sys_i) begin
      cyc++;
      if (req.wr === 1'b1) begin
         n_wr++;
         last = req;
      end
      if (req.rd === 1'b1)
         n_rd++;
      if (cyc > 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // own crc model, msb first, zero start
   function automatic logic [7:0] fcs(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   // what the map stub answers for an address
   function automatic logic [15:0] rdv(input logic [6:0] a);
      return {a, ~a, a[1:0]};
   endfunction

   function automatic logic [39:0] fr(input logic [23:0] d);
      return {8'h00, d, fcs(d)};
   endfunction

   function automatic logic [31:0] rsp(input logic rw, input logic f, input logic [15:0] d);
      return {rw, f, st, d, fcs({rw, f, st, d})};
   endfunction

   task automatic fx(input logic [39:0] d, input int n, input logic cp = 1'b0,
                     input logic fe = 1'b0);
      i_host.spi(d, n, cp, fe, q, oe);
   endtask

   initial begin
      rstn_i = 1'b0;
      cfg = 7'h01;
      st = 6'h2A;
      irq = 1'b1;
      i_host.hp(5);
      rstn_i = 1'b1;
      i_host.hp(4);
      chk({sdo_oe, utx, map, clr}, 4'h4);
      chk(req, '0);
      $display("test reset done");
      // write, read, then a zero write to address 0 that brings the read data back
      fx(fr({1'b0, 7'h05, 16'h1234}), 32);
      chk({last.addr, last.wdata}, {7'h05, 16'h1234});
      fx(fr({1'b1, 7'h05, 16'hFFFF}), 32);
      chk(q[31:0], rsp(1'b0, 1'b0, 16'h0000));
      chk({n_rd, oe}, {32'd1, 1'b1});
      fx(40'h0, 32);
      chk(q[31:0], rsp(1'b1, 1'b0, rdv(7'h05)));
      $display("test read write done");
      // bad crc, then a short frame, then a long one
      st = 6'h15;
      fx(fr({1'b0, 7'h06, 16'h0F0F}) ^ 40'h1, 32);
      chk(n_wr, 2);
      fx(40'hF_FFFF, 20);
      chk(q[19:0], rsp(1'b0, 1'b1, 16'h0000) >> 12);
      chk(n_wr, 2);
      fx(fr({1'b0, 7'h09, 16'h5A5A}) | 40'h02_0000_0000, 34);
      chk(q[33:0], {rsp(1'b0, 1'b1, 16'h0000), 2'b10});
      chk({last.addr, last.wdata}, {7'h09, 16'h5A5A});
      fx(fr({1'b0, 7'h7F, 16'h0001}), 32);
      chk({n_wr, map}, {32'd3, 1'b0});
      $display("test frame errors done");
      // short frames with idle-high clock, then falling-edge readout
      cfg.frame_check_on = 1'b0;
      fx({1'b1, 7'h11, 16'h0000}, 24, 1'b1);
      fx(40'h0, 24, 1'b1);
      chk(q[23:0], rsp(1'b1, 1'b0, rdv(7'h11)) >> 8);
      cfg = 7'h09;
      fx(fr({1'b1, 7'h22, 16'h0000}), 32, 1'b0, 1'b1);
      fx(40'h0, 32, 1'b0, 1'b1);
      chk(q[31:0], rsp(1'b1, 1'b0, rdv(7'h22)));
      cfg = 7'h11;
      fx(fr({1'b1, 7'h05, 16'h0000}), 32);
      chk(oe, 1'b0);
      cfg = 7'h21;
      fx(40'h0, 32);
      chk({n_rd, oe}, {32'd4, 1'b0});
      $display("test modes done");
      // spi only: interrupt on the uart transmit pin, uart ignored
      cfg = 7'h45;
      irq = 1'b0;
      i_host.hp(4);
      chk(utx, 1'b0);
      i_host.ucmd({1'b0, 7'h7F, 16'h0001});
      chk(map, 1'b0);
      // uart takes over the map
      cfg = 7'h07;
      i_host.ucmd({1'b0, 7'h7F, 16'h0001});
      chk(map, 1'b1);
      fx(fr({1'b0, 7'h05, 16'h1111}), 32);
      chk(n_wr, 6);
      i_host.ucmd({1'b0, 7'h03, 16'hBEEF});
      chk({last.addr, last.wdata}, {7'h03, 16'hBEEF});
      chk({sdo_oe, sdo}, 2'b10);
      irq = 1'b1;
      i_host.sdi_o = 1'b1;
      i_host.hp(8);
      chk({sdo_oe, sdo, clr}, 3'h7);
      i_host.sdi_o = 1'b0;
      i_host.hp(8);
      chk(clr, 1'b0);
      // a reset in mid-run drops the uart map access
      rstn_i = 1'b0;
      i_host.hp(4);
      rstn_i = 1'b1;
      i_host.hp(4);
      chk(map, 1'b0);
      i_host.ucmd({1'b0, 7'h7F, 16'h0001});
      chk(map, 1'b1);
      $display("test uart done");
      report_and_stop();
   end
endmodule
